// File: shared/pudc_pkg.sv
// Shared constants for the presettable up/down counter stage and its controller.
// Assumes both ends run on the one 10 MHz system clock mclk.
package pudc_pkg;

    // Count width and terminal values
    localparam int COUNT_W = 4;
    localparam logic [3:0] COUNT_MAX = 4'hf;
    localparam logic [3:0] COUNT_MIN = 4'h0;

    // Clock figures
    localparam int MCLK_HZ = 10000000;
    localparam int MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;

    // Controller register word indices on the Avalon-MM port
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_PRESET = 3'h1;
    localparam logic [2:0] REG_CMD = 3'h2;
    localparam logic [2:0] REG_DIVISOR = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_IRQ_STATUS = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK = 3'h6;

    // Control register fields
    localparam int CTRL_UP = 0;
    localparam int CTRL_HOLD = 1;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_DIVIDE = 3;
    localparam int CTRL_W = 4;

    // Command register fields
    localparam int CMD_LOAD = 0;
    localparam int CMD_CLEAR = 1;

    // Status register fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_CARRY = 4;

    // Interrupt status and mask fields
    localparam int IRQ_W = 3;
    localparam int IRQ_TERMINAL = 0;
    localparam int IRQ_RELOAD = 1;
    localparam int IRQ_ZERO_RATIO = 2;

    // Count clock half period in mclk cycles, minus one
    localparam int DIV_W = 16;
    localparam logic [15:0] DIV_RESET = 16'h0004;

    // Reset values of the control fields
    localparam logic [3:0] CTRL_RESET = 4'h2;
    localparam logic [3:0] PRESET_RESET = 4'h0;

endpackage : pudc_pkg

// File: shared/pudc_link_if.sv
// Link between one counter stage and its controlling logic.
// Assumes both ends are clocked by the same mclk; all signals are plain levels.
`timescale 1ns/100ps
`default_nettype none

interface pudc_link_if;
    logic count_clk;
    logic up_down;
    logic carry_in_n;
    logic load_strobe;
    logic clear;
    logic preset_bit0;
    logic preset_bit1;
    logic preset_bit2;
    logic preset_bit3;
    logic count_bit0;
    logic count_bit1;
    logic count_bit2;
    logic count_bit3;
    logic carry_out_n;

    // Counter stage end
    modport stage (
        input count_clk, up_down, carry_in_n, load_strobe, clear,
        input preset_bit0, preset_bit1, preset_bit2, preset_bit3,
        output count_bit0, count_bit1, count_bit2, count_bit3, carry_out_n
    );

    // Controlling logic end
    modport ctrl (
        output count_clk, up_down, carry_in_n, load_strobe, clear,
        output preset_bit0, preset_bit1, preset_bit2, preset_bit3,
        input count_bit0, count_bit1, count_bit2, count_bit3, carry_out_n
    );
endinterface : pudc_link_if

`default_nettype wire

// File: logic/pudc_stage.sv
// Four-bit presettable synchronous up/down counter stage.
// Assumes the link inputs come from logic on mclk, so they are read unsynchronised.
// The count clock is a level on the link; its rising edge is found on mclk.
//
// Overview of operation
// - Count on count clock rise when enabled
// - Direction high counts up, low down
// - Carry input high holds the count
// - Count shown on four bits, bit0 lowest
// - Load strobe copies preset bits into counter
// - Load acts without count edge, blocks counting
// - Clear zeroes count without edge, blocks counting
// - Carry output active low, follows count state
// - Carry low while count rests at terminal value for the direction set and carry input is low
// - Controller drives carry input from hold bit, clocks the stage
// - Controller drops load, clear before rise
// - Controller presets binary divide ratio
// - Divider counts down, ratio zero avoided
// - Up mode carry low at fifteen, input low
// - Down mode carry low at zero, input low
`timescale 1ns/100ps
`default_nettype none

module pudc_stage (
    input wire logic mclk,
    input wire logic resetn,
    pudc_link_if.stage link,
    output logic [3:0] count_value,
    output logic terminal_n
);

    // What the stage does at a given mclk edge
    typedef enum logic [1:0] {
        PUDC_ACT_HOLD,
        PUDC_ACT_CLEAR,
        PUDC_ACT_LOAD,
        PUDC_ACT_COUNT
    } pudc_action_t;

    // All state of the stage
    typedef struct packed {
        logic [3:0] count;
        logic clk_prev;
        logic carry_n;
    } pudc_stage_state_t;

    pudc_stage_state_t st;
    pudc_stage_state_t next_st;

    logic [3:0] preset;
    logic count_rise;
    pudc_action_t action;
    logic [3:0] toggles;

    // Pick the action; clear first, then load, then a counting edge
    function automatic pudc_action_t decode_action(
        input logic clear_in,
        input logic load_in,
        input logic rise_in,
        input logic carry_in_n_in
    );
        pudc_action_t act;
        act = PUDC_ACT_HOLD;
        if (clear_in) begin
            act = PUDC_ACT_CLEAR;
        end else if (load_in) begin
            act = PUDC_ACT_LOAD;
        end else if (rise_in && !carry_in_n_in) begin
            act = PUDC_ACT_COUNT;
        end
        return act;
    endfunction : decode_action

    // Toggle term of each bit: bit0 always, higher bits when all
    // lower bits are ones (up) or zeros (down)
    function automatic logic [3:0] toggle_terms(
        input logic [3:0] cnt,
        input logic up
    );
        logic [3:0] t;
        t = 4'h0;
        t[0] = 1'b1;
        for (int i = 1; i < pudc_pkg::COUNT_W; i++) begin
            t[i] = t[i - 1] & (up ? cnt[i - 1] : ~cnt[i - 1]);
        end
        return t;
    endfunction : toggle_terms

    // Active-low carry from a count state, direction and carry input
    function automatic logic carry_of(
        input logic [3:0] cnt,
        input logic up,
        input logic carry_in_n_in
    );
        logic at_end;
        at_end = up ? (cnt == pudc_pkg::COUNT_MAX)
                    : (cnt == pudc_pkg::COUNT_MIN);
        return ~(at_end & ~carry_in_n_in);
    endfunction : carry_of

    // Gather the preset bits, bit0 lowest
    assign preset = {link.preset_bit3, link.preset_bit2, link.preset_bit1, link.preset_bit0};

    // Rising edge of the count clock level
    assign count_rise = link.count_clk & ~st.clk_prev;

    // Decode of this cycle's action and the per-bit toggle terms
    assign action = decode_action(link.clear, link.load_strobe, count_rise, link.carry_in_n);
    assign toggles = toggle_terms(st.count, link.up_down);

    // Next state: the counter bits and the registered carry
    always_comb begin
        next_st = st;
        next_st.clk_prev = link.count_clk;
        unique case (action)
            PUDC_ACT_CLEAR: begin
                // Clear wins over everything, count edges ignored
                next_st.count = pudc_pkg::COUNT_MIN;
            end
            PUDC_ACT_LOAD: begin
                // Parallel load at once, count edges ignored
                next_st.count = preset;
            end
            PUDC_ACT_COUNT: begin
                // Toggle stages give natural wrap 15->0 and 0->15
                next_st.count = st.count ^ toggles;
            end
            PUDC_ACT_HOLD: begin
                // Carry input high or no edge: keep the count
                next_st.count = st.count;
            end
        endcase
        // Carry follows the new count, direction and carry input each cycle; it is low
        // only while the count is at its terminal value and the carry input is low
        next_st.carry_n = carry_of(next_st.count, link.up_down, link.carry_in_n);
    end

    // State register; reset gives count zero and carry high
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st.count <= pudc_pkg::COUNT_MIN;
            st.clk_prev <= 1'b0;
            st.carry_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Link outputs straight from the count and carry flops
    assign link.count_bit0 = st.count[0];
    assign link.count_bit1 = st.count[1];
    assign link.count_bit2 = st.count[2];
    assign link.count_bit3 = st.count[3];
    assign link.carry_out_n = st.carry_n;

    // User-side copies of the same flops
    assign count_value = st.count;
    assign terminal_n = st.carry_n;

endmodule : pudc_stage

`default_nettype wire

// File: logic/pudc_ctrl.sv
// Controlling logic for one counter stage, with an Avalon-MM slave port.
// Assumes the stage runs on the same mclk and answers with registered outputs.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pudc_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    pudc_link_if.ctrl link,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);

    // All state of the controller
    typedef struct packed {
        logic [3:0] ctrl;
        logic [3:0] preset;
        logic [15:0] div;
        logic [15:0] div_cnt;
        logic count_clk;
        logic load;
        logic clear;
        logic load_pend;
        logic clear_pend;
        logic carry_prev;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
    } pudc_ctrl_state_t;

    pudc_ctrl_state_t st;
    pudc_ctrl_state_t next_st;

    logic [3:0] count_in;
    logic carry_fall;

    assign count_in = {link.count_bit3, link.count_bit2, link.count_bit1, link.count_bit0};
    assign carry_fall = st.carry_prev & ~link.carry_out_n;

    // Bus slave, count clock divider, command issue and events
    always_comb begin
        logic [31:0] rd;
        logic [2:0] ev;
        rd = 32'h0;
        ev = 3'h0;
        next_st = st;
        next_st.load = 1'b0;
        next_st.clear = 1'b0;
        next_st.carry_prev = link.carry_out_n;
        unique case (avs_address)
            pudc_pkg::REG_CTRL: rd[3:0] = st.ctrl;
            pudc_pkg::REG_PRESET: rd[3:0] = st.preset;
            pudc_pkg::REG_DIVISOR: rd[15:0] = st.div;
            pudc_pkg::REG_STATUS: begin
                rd[pudc_pkg::STAT_COUNT_LSB +: pudc_pkg::COUNT_W] = count_in;
                rd[pudc_pkg::STAT_CARRY] = link.carry_out_n;
            end
            pudc_pkg::REG_IRQ_STATUS: rd[2:0] = st.irq_stat;
            pudc_pkg::REG_IRQ_MASK: rd[2:0] = st.irq_mask;
            default: rd = 32'h0;
        endcase
        // Issue clear or load for one cycle with the count clock low and
        // the divider restarted, so the next rise is div+1 cycles away;
        // done before new requests merge in, so a same-cycle request is kept
        if (st.clear_pend) begin
            next_st.clear = 1'b1;
            next_st.clear_pend = 1'b0;
            next_st.count_clk = 1'b0;
            next_st.div_cnt = st.div;
        end else if (st.load_pend) begin
            next_st.load = 1'b1;
            next_st.load_pend = 1'b0;
            next_st.count_clk = 1'b0;
            next_st.div_cnt = st.div;
        end else if (st.div_cnt == 16'h0) begin
            next_st.div_cnt = st.div;
            next_st.count_clk = st.ctrl[pudc_pkg::CTRL_RUN] ? ~st.count_clk : 1'b0;
        end else begin
            next_st.div_cnt = st.div_cnt - 16'h1;
        end
        // First cycle of a request: capture read data, drop waitrequest
        if ((avs_read || avs_write) && st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            next_st.readdata = avs_read ? rd : st.readdata;
        end
        // Transfer completes at the edge that sees waitrequest low
        if ((avs_read || avs_write) && !st.waitrequest) begin
            next_st.waitrequest = 1'b1;
            if (avs_write) begin
                unique case (avs_address)
                    pudc_pkg::REG_CTRL: begin
                        next_st.ctrl = avs_writedata[3:0];
                        // Divider use always counts down
                        if (avs_writedata[pudc_pkg::CTRL_DIVIDE]) begin
                            next_st.ctrl[pudc_pkg::CTRL_UP] = 1'b0;
                        end
                    end
                    pudc_pkg::REG_PRESET: next_st.preset = avs_writedata[3:0];
                    pudc_pkg::REG_CMD: begin
                        next_st.load_pend = next_st.load_pend | avs_writedata[pudc_pkg::CMD_LOAD];
                        next_st.clear_pend = next_st.clear_pend | avs_writedata[pudc_pkg::CMD_CLEAR];
                    end
                    pudc_pkg::REG_DIVISOR: next_st.div = avs_writedata[15:0];
                    pudc_pkg::REG_IRQ_STATUS: next_st.irq_stat = st.irq_stat & ~avs_writedata[2:0];
                    pudc_pkg::REG_IRQ_MASK: next_st.irq_mask = avs_writedata[2:0];
                    default: next_st.ctrl = st.ctrl;
                endcase
            end
        end
        // Events from the stage carry; divide mode reloads a nonzero preset
        if (carry_fall) begin
            ev[pudc_pkg::IRQ_TERMINAL] = 1'b1;
            if (st.ctrl[pudc_pkg::CTRL_DIVIDE]) begin
                if (st.preset == pudc_pkg::COUNT_MIN) begin
                    ev[pudc_pkg::IRQ_ZERO_RATIO] = 1'b1;
                end else begin
                    ev[pudc_pkg::IRQ_RELOAD] = 1'b1;
                    next_st.load_pend = 1'b1;
                end
            end
        end
        // Set wins over a same-cycle write-one-to-clear
        next_st.irq_stat = next_st.irq_stat | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{ctrl: pudc_pkg::CTRL_RESET, preset: pudc_pkg::PRESET_RESET,
                    div: pudc_pkg::DIV_RESET, div_cnt: pudc_pkg::DIV_RESET,
                    count_clk: 1'b0, load: 1'b0, clear: 1'b0, load_pend: 1'b0,
                    clear_pend: 1'b0, carry_prev: 1'b1, irq_stat: 3'h0,
                    irq_mask: 3'h0, waitrequest: 1'b1, readdata: 32'h0, irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Link drive; carry input from the hold bit, all from flops
    assign link.count_clk = st.count_clk;
    assign link.up_down = st.ctrl[pudc_pkg::CTRL_UP];
    assign link.carry_in_n = st.ctrl[pudc_pkg::CTRL_HOLD];
    assign link.load_strobe = st.load;
    assign link.clear = st.clear;
    assign link.preset_bit0 = st.preset[0];
    assign link.preset_bit1 = st.preset[1];
    assign link.preset_bit2 = st.preset[2];
    assign link.preset_bit3 = st.preset[3];

    // Bus outputs
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign irq = st.irq;

endmodule : pudc_ctrl

`default_nettype wire

// File: sim/pudc_link_sva.sv
// Concurrent checks on the link between one counter stage and its controller.
// Assumes the single clock mclk and the active-low asynchronous reset resetn.
`timescale 1ns/100ps
`default_nettype none

module pudc_link_sva (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic count_clk,
    input wire logic up_down,
    input wire logic carry_in_n,
    input wire logic load_strobe,
    input wire logic clear,
    input wire logic preset_bit0,
    input wire logic preset_bit1,
    input wire logic preset_bit2,
    input wire logic preset_bit3,
    input wire logic count_bit0,
    input wire logic count_bit1,
    input wire logic count_bit2,
    input wire logic count_bit3,
    input wire logic carry_out_n
);
    logic [3:0] cnt;
    logic [3:0] pre;
    logic go;

    // Gather loose bits into words
    assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
    assign pre = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};
    assign go = !clear && !load_strobe;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_COUNT_UP: assert property (
        go && !carry_in_n && $rose(count_clk) && up_down |=> cnt == $past(cnt) + 4'h1
    ) else $error("Count did not step up");
    AST_COUNT_DOWN: assert property (
        go && !carry_in_n && $rose(count_clk) && !up_down |=> cnt == $past(cnt) - 4'h1
    ) else $error("Count did not step down");
    AST_HOLD: assert property (
        go && carry_in_n |=> $stable(cnt)
    ) else $error("Count moved while carry input high");
    AST_NO_EDGE: assert property (
        go && !$rose(count_clk) |=> $stable(cnt)
    ) else $error("Count moved without a count edge");
    AST_LOAD: assert property (
        load_strobe && !clear |=> cnt == $past(pre)
    ) else $error("Preset not loaded");
    AST_CLEAR: assert property (
        clear |=> cnt == 4'h0
    ) else $error("Clear did not zero the count");
    AST_CARRY_UP: assert property (
        up_down && !carry_in_n |=> carry_out_n == (cnt != 4'hf)
    ) else $error("Up carry wrong");
    AST_CARRY_DOWN: assert property (
        !up_down && !carry_in_n |=> carry_out_n == (cnt != 4'h0)
    ) else $error("Down carry wrong");
    AST_CARRY_OFF: assert property (
        carry_in_n |=> carry_out_n
    ) else $error("Carry low while carry input high");

    // Main scenarios reached
    cover property (load_strobe);
    cover property (!carry_out_n && up_down);
    cover property (!carry_out_n && !up_down);
endmodule : pudc_link_sva

`default_nettype wire

// File: sim/tb.sv
// Testbench: controller and counter stage joined by the link, driven over Avalon-MM.
// Assumes the register map and one-wait-cycle answer of the controller.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic mclk = 1'b0;
    logic resetn;
    logic [2:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [3:0] count_value;
    logic terminal_n;
    logic [31:0] rd;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    pudc_link_if link ();
    pudc_stage u_pudc_stage (.mclk(mclk), .resetn(resetn), .link(link.stage), .count_value(count_value),
        .terminal_n(terminal_n));
    pudc_ctrl u_pudc_ctrl (.mclk(mclk), .resetn(resetn), .link(link.ctrl), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
    pudc_link_sva u_pudc_link_sva (.mclk(mclk), .resetn(resetn), .count_clk(link.count_clk),
        .up_down(link.up_down), .carry_in_n(link.carry_in_n), .load_strobe(link.load_strobe),
        .clear(link.clear), .preset_bit0(link.preset_bit0), .preset_bit1(link.preset_bit1),
        .preset_bit2(link.preset_bit2), .preset_bit3(link.preset_bit3), .count_bit0(link.count_bit0),
        .count_bit1(link.count_bit1), .count_bit2(link.count_bit2), .count_bit3(link.count_bit3),
        .carry_out_n(link.carry_out_n));

    // Clock and hang guard
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            test_done();
        end
    end

    task test_done;
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon-MM transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task rd_chk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task wait_carry(input logic v);
        int n;
        n = 0;
        while (link.carry_out_n !== v && n < 400) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_carry

    // Main sequence
    initial begin
        resetn = 1'b0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(pudc_pkg::REG_STATUS, 32'h10);
        rd_chk(pudc_pkg::REG_CTRL, 32'h2);
        rd_chk(pudc_pkg::REG_DIVISOR, 32'h4);
        rd_chk(3'h7, 32'h0);
        rd_chk(pudc_pkg::REG_CMD, 32'h0);
        bus(1'b1, pudc_pkg::REG_DIVISOR, 32'h1);
        bus(1'b1, pudc_pkg::REG_PRESET, 32'he);
        bus(1'b1, pudc_pkg::REG_CMD, 32'h1);
        repeat (3) @(posedge mclk);
        rd_chk(pudc_pkg::REG_STATUS, 32'h1e);
        // Held stage ignores a running count clock
        bus(1'b1, pudc_pkg::REG_CTRL, 32'h6);
        repeat (30) @(posedge mclk);
        rd_chk(pudc_pkg::REG_STATUS, 32'h1e);
        // Up count through terminal value and wrap
        bus(1'b1, pudc_pkg::REG_CTRL, 32'h5);
        wait_carry(1'b0);
        check({28'h0, count_value}, 32'hf);
        check({31'h0, terminal_n}, 32'h0);
        wait_carry(1'b1);
        check({28'h0, count_value}, 32'h0);
        // Down count through zero and wrap
        bus(1'b1, pudc_pkg::REG_CTRL, 32'h6);
        bus(1'b1, pudc_pkg::REG_PRESET, 32'h2);
        bus(1'b1, pudc_pkg::REG_CMD, 32'h1);
        bus(1'b1, pudc_pkg::REG_CTRL, 32'h4);
        wait_carry(1'b0);
        check({28'h0, count_value}, 32'h0);
        wait_carry(1'b1);
        check({28'h0, count_value}, 32'hf);
        // Terminal event: sticky, masked, then cleared
        bus(1'b1, pudc_pkg::REG_CTRL, 32'h6);
        check({31'h0, irq}, 32'h0);
        rd_chk(pudc_pkg::REG_IRQ_STATUS, 32'h1);
        bus(1'b1, pudc_pkg::REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, pudc_pkg::REG_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(pudc_pkg::REG_IRQ_STATUS, 32'h0);
        // Clear alone, then clear and load together: clear served first
        bus(1'b1, pudc_pkg::REG_PRESET, 32'h9);
        bus(1'b1, pudc_pkg::REG_CMD, 32'h2);
        repeat (3) @(posedge mclk);
        rd_chk(pudc_pkg::REG_STATUS, 32'h10);
        bus(1'b1, pudc_pkg::REG_CMD, 32'h3);
        repeat (3) @(posedge mclk);
        rd_chk(pudc_pkg::REG_STATUS, 32'h19);
        // Divider: up request forced down, preset reloaded at terminal count
        bus(1'b1, pudc_pkg::REG_PRESET, 32'h3);
        bus(1'b1, pudc_pkg::REG_CTRL, 32'hd);
        rd_chk(pudc_pkg::REG_CTRL, 32'hc);
        wait_carry(1'b0);
        wait_carry(1'b1);
        check({28'h0, count_value}, 32'h3);
        bus(1'b1, pudc_pkg::REG_CTRL, 32'he);
        rd_chk(pudc_pkg::REG_IRQ_STATUS, 32'h3);
        check({31'h0, irq}, 32'h1);
        // Ratio zero: refused, no reload, count wraps
        bus(1'b1, pudc_pkg::REG_PRESET, 32'h0);
        bus(1'b1, pudc_pkg::REG_IRQ_STATUS, 32'h7);
        bus(1'b1, pudc_pkg::REG_CTRL, 32'hc);
        wait_carry(1'b0);
        wait_carry(1'b1);
        check({28'h0, count_value}, 32'hf);
        rd_chk(pudc_pkg::REG_IRQ_STATUS, 32'h5);
        test_done();
    end
endmodule : tb

`default_nettype wire
